/* File: shared/bij_defs.svh */
// timing counts, codes and field constants for the boot integrity block
`ifndef BIJ_DEFS_SVH
`define BIJ_DEFS_SVH
`define BIJ_CLK_HZ 20000000
`define BIJ_ERASE_MS 160
`define BIJ_ERASE_CYC ((`BIJ_CLK_HZ / 1000) * `BIJ_ERASE_MS)
`define BIJ_WDOG_CYC 200000
`define BIJ_JTAG_ADDR 7'h7E
`define BIJ_ROM_MODE_CMD 8'hD9
`define BIJ_GPIO_JTAG_W 4
`define BIJ_PWM_W 8
`define BIJ_GPIO_W 8
`define BIJ_ECC_W 6
`define BIJ_DATA_W 32
`define BIJ_ADDR_W 7
`endif

/* File: shared/bij_pkg.sv */
// types for the boot integrity block
package bij_pkg;
  typedef enum logic [2:0] {
    BIJ_ST_FW_CHK   = 3'h0,
    BIJ_ST_CFG_CHK  = 3'h1,
    BIJ_ST_LOG_CHK  = 3'h3,
    BIJ_ST_ERASE    = 3'h2,
    BIJ_ST_RUN      = 3'h6,
    BIJ_ST_WAIT_BUS = 3'h7,
    BIJ_ST_ROM      = 3'h5
  } bij_state_type;

  typedef struct packed {
    logic fw_ok;
    logic cfg_ok;
    logic log_ok;
    logic flash_blank;
  } bij_boot_chk_type;

  typedef struct packed {
    logic [7:0] code;
    logic [15:0] value;
    logic [15:0] min;
    logic [15:0] max;
    logic valid;
    logic pec_present;
    logic pec_ok;
  } bij_cmd_type;

  typedef struct packed {
    logic cfg_fallback;
    logic param_reject;
    logic log_erased;
    logic fw_halted;
    logic rom_mode;
    logic jtag_en;
    logic ecc_corrected;
  } bij_status_type;
endpackage

/* File: rtl/bij_top.sv */
// boot integrity checks, jtag enable decision, watchdog, ecc and command screening
`include "bij_defs.svh"
module bij_top
  import bij_pkg::*;
#(
  parameter int unsigned ERASE_CYC = `BIJ_ERASE_CYC,
  parameter int unsigned WDOG_CYC = `BIJ_WDOG_CYC
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire bij_boot_chk_type boot_chk_i,
  input wire logic [`BIJ_ADDR_W-1:0] bus_addr_i,
  input wire logic addr_fault_i,
  input wire logic wdog_kick_i,
  input wire logic tool_connect_i,
  input wire bij_cmd_type cmd_i,
  input wire logic [`BIJ_GPIO_JTAG_W-1:0] shared_pin_i,
  input wire logic [`BIJ_GPIO_JTAG_W-1:0] gpio_out_i,
  input wire logic [`BIJ_GPIO_W-1:0] gpio_drive_i,
  input wire logic [`BIJ_PWM_W-1:0] fast_pulse_width_pin_i,
  input wire logic log_wr_i,
  input wire logic [`BIJ_DATA_W-1:0] log_sum_i,
  input wire logic ecc_wr_i,
  input wire logic [`BIJ_DATA_W-1:0] ecc_wdata_i,
  input wire logic ecc_rd_i,
  input wire logic [`BIJ_DATA_W+`BIJ_ECC_W-1:0] ecc_rword_i,
  output logic jtag_en_o,
  output logic [`BIJ_GPIO_JTAG_W-1:0] gpio_in_o,
  output logic [`BIJ_GPIO_JTAG_W-1:0] shared_pin_o,
  output logic [`BIJ_GPIO_JTAG_W-1:0] shared_pin_oe_n_o,
  output logic [`BIJ_GPIO_W-1:0] gpio_oe_n_o,
  output logic [`BIJ_PWM_W-1:0] fast_pulse_width_pin_o,
  output logic bus_alert_output_o,
  output logic fw_run_o,
  output logic factory_cfg_o,
  output logic log_erase_o,
  output logic [`BIJ_DATA_W-1:0] log_sum_o,
  output logic soft_reset_o,
  output logic param_ok_o,
  output logic cmd_accept_o,
  output logic [`BIJ_DATA_W+`BIJ_ECC_W-1:0] ecc_wword_o,
  output logic [`BIJ_DATA_W-1:0] ecc_rdata_o,
  output logic ecc_err_o,
  output bij_status_type status_o
);

  ////////////////////////////////////////////////////////////////////////////
  // ecc: hamming over 32 data bits, 6 check bits (single-error correcting)
  function automatic logic [`BIJ_ECC_W-1:0] ecc_gen(input logic [`BIJ_DATA_W-1:0] d);
    logic [`BIJ_ECC_W-1:0] c;
    int unsigned pos;
    c = '0;
    pos = 1;
    for (int i = 0; i < `BIJ_DATA_W; i++) begin
      pos = pos + 1;
      while ((pos & (pos - 1)) == 0) pos = pos + 1;
      for (int k = 0; k < `BIJ_ECC_W; k++) begin
        if (pos[k]) c[k] = c[k] ^ d[i];
      end
    end
    return c;
  endfunction

  function automatic logic [`BIJ_DATA_W-1:0] ecc_fix(input logic [`BIJ_DATA_W-1:0] d,
                                                     input logic [`BIJ_ECC_W-1:0] syn);
    logic [`BIJ_DATA_W-1:0] r;
    int unsigned pos;
    r = d;
    pos = 1;
    for (int i = 0; i < `BIJ_DATA_W; i++) begin
      pos = pos + 1;
      while ((pos & (pos - 1)) == 0) pos = pos + 1;
      if (syn == pos[`BIJ_ECC_W-1:0]) r[i] = ~d[i];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; unreset so the address has settled when boot samples it
  logic [`BIJ_GPIO_JTAG_W-1:0] pin_s1_r;
  logic [`BIJ_GPIO_JTAG_W-1:0] pin_s2_r;
  logic [`BIJ_ADDR_W:0] addr_s1_r;
  logic [`BIJ_ADDR_W:0] addr_s2_r;

  always_ff @(posedge core_clk_i) begin
    if (clk_en_i) begin
      pin_s1_r <= shared_pin_i;
      pin_s2_r <= pin_s1_r;
      addr_s1_r <= {addr_fault_i, bus_addr_i};
      addr_s2_r <= addr_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot sequence
  bij_state_type state_r, state_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [31:0] wdog_r, wdog_nxt;
  logic jtag_r, jtag_nxt;
  logic fac_r, fac_nxt;
  logic alert_r, alert_nxt;
  logic erase_r, erase_nxt;
  logic wdrst_r, wdrst_nxt;
  logic [`BIJ_DATA_W-1:0] sum_r, sum_nxt;
  bij_status_type st_r, st_nxt;
  logic accept_r, accept_nxt;
  logic pok_r, pok_nxt;
  logic in_boot;
  logic range_ok;
  logic pec_ok;
  logic run_r, run_nxt;
  logic [`BIJ_ECC_W-1:0] syn;
  logic ecc_err_nxt;

  assign in_boot = (state_r == BIJ_ST_FW_CHK);
  assign range_ok = (cmd_i.value >= cmd_i.min) && (cmd_i.value <= cmd_i.max);
  // pec optional: only checked when the host appended one
  assign pec_ok = !cmd_i.pec_present || cmd_i.pec_ok;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    wdog_nxt = wdog_r;
    jtag_nxt = jtag_r;
    fac_nxt = fac_r;
    alert_nxt = alert_r;
    erase_nxt = 1'b0;
    wdrst_nxt = 1'b0;
    sum_nxt = sum_r;
    st_nxt = st_r;
    accept_nxt = 1'b0;
    pok_nxt = pok_r;
    st_nxt.ecc_corrected = 1'b0;
    unique case (state_r)
      BIJ_ST_FW_CHK: begin
        // decision taken once, held to next reset
        jtag_nxt = boot_chk_i.flash_blank
                   || addr_s2_r[`BIJ_ADDR_W]
                   || (addr_s2_r[`BIJ_ADDR_W-1:0] == `BIJ_JTAG_ADDR);
        if (!boot_chk_i.fw_ok) begin
          state_nxt = BIJ_ST_WAIT_BUS;
          st_nxt.fw_halted = 1'b1;
        end else begin
          state_nxt = BIJ_ST_CFG_CHK;
        end
      end
      BIJ_ST_CFG_CHK: begin
        if (!boot_chk_i.cfg_ok) begin
          fac_nxt = 1'b1;
          alert_nxt = 1'b1;
          st_nxt.cfg_fallback = 1'b1;
        end
        state_nxt = BIJ_ST_LOG_CHK;
      end
      BIJ_ST_LOG_CHK: begin
        if (boot_chk_i.log_ok) begin
          state_nxt = BIJ_ST_RUN;
        end else begin
          state_nxt = BIJ_ST_ERASE;
          cnt_nxt = 32'h0;
          st_nxt.log_erased = 1'b1;
        end
      end
      BIJ_ST_ERASE: begin
        // start-up stretched by the erase time
        erase_nxt = 1'b1;
        cnt_nxt = cnt_r + 32'h1;
        if (cnt_r >= ERASE_CYC - 1) begin
          state_nxt = BIJ_ST_RUN;
          sum_nxt = '0;
        end
      end
      BIJ_ST_RUN: begin
        if (log_wr_i) sum_nxt = log_sum_i;
        wdog_nxt = wdog_kick_i ? 32'h0 : wdog_r + 32'h1;
        if (wdog_r >= WDOG_CYC - 1) begin
          wdrst_nxt = 1'b1;
          wdog_nxt = 32'h0;
        end
        if (cmd_i.valid && pec_ok) begin
          if (cmd_i.code == `BIJ_ROM_MODE_CMD) begin
            state_nxt = BIJ_ST_ROM;
            st_nxt.rom_mode = 1'b1;
          end else begin
            pok_nxt = range_ok;
            accept_nxt = range_ok;
            st_nxt.param_reject = st_r.param_reject | ~range_ok;
          end
        end
      end
      BIJ_ST_WAIT_BUS: begin
        // firmware never runs; only bus rom-mode entry honoured
        if (cmd_i.valid && pec_ok && cmd_i.code == `BIJ_ROM_MODE_CMD) begin
          state_nxt = BIJ_ST_ROM;
          st_nxt.rom_mode = 1'b1;
        end
      end
      BIJ_ST_ROM: begin
        if (tool_connect_i) begin
          wdrst_nxt = 1'b1; // tool takes over and restarts device
        end
      end
      default: state_nxt = BIJ_ST_FW_CHK;
    endcase
    st_nxt.jtag_en = jtag_nxt;
    run_nxt = (state_nxt == BIJ_ST_RUN);
    if (ecc_rd_i && ecc_err_nxt) st_nxt.ecc_corrected = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // ecc datapath
  logic [`BIJ_DATA_W+`BIJ_ECC_W-1:0] wword_r, wword_nxt;
  logic [`BIJ_DATA_W-1:0] rdata_r, rdata_nxt;
  logic eerr_r, eerr_nxt;

  assign syn = ecc_gen(ecc_rword_i[`BIJ_DATA_W-1:0]) ^ ecc_rword_i[`BIJ_DATA_W+`BIJ_ECC_W-1:`BIJ_DATA_W];
  assign ecc_err_nxt = (syn != '0);

  always_comb begin
    wword_nxt = wword_r;
    rdata_nxt = rdata_r;
    eerr_nxt = eerr_r;
    if (ecc_wr_i) wword_nxt = {ecc_gen(ecc_wdata_i), ecc_wdata_i};
    if (ecc_rd_i) begin
      rdata_nxt = ecc_fix(ecc_rword_i[`BIJ_DATA_W-1:0], syn);
      eerr_nxt = ecc_err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin muxing: jtag owns the four shared pins only when enabled
  logic [`BIJ_GPIO_JTAG_W-1:0] gin_r, gin_nxt;
  logic [`BIJ_GPIO_JTAG_W-1:0] pout_r, pout_nxt;
  logic [`BIJ_GPIO_JTAG_W-1:0] poe_n_r, poe_n_nxt;
  logic [`BIJ_GPIO_W-1:0] goe_n_r, goe_n_nxt;
  logic [`BIJ_PWM_W-1:0] pwm_r, pwm_nxt;

  always_comb begin
    // tap itself lives elsewhere; no boundary-scan cells here
    gin_nxt = jtag_r ? '0 : pin_s2_r;
    pout_nxt = gpio_out_i;
    poe_n_nxt = jtag_r ? '1 : ~gpio_out_i;
    goe_n_nxt = in_boot ? '1 : ~gpio_drive_i;
    pwm_nxt = in_boot ? '0 : fast_pulse_width_pin_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= BIJ_ST_FW_CHK;
      cnt_r <= 32'h0;
      wdog_r <= 32'h0;
      jtag_r <= 1'b0;
      fac_r <= 1'b0;
      alert_r <= 1'b0;
      erase_r <= 1'b0;
      wdrst_r <= 1'b0;
      sum_r <= '0;
      st_r <= '0;
      accept_r <= 1'b0;
      pok_r <= 1'b0;
      wword_r <= '0;
      rdata_r <= '0;
      eerr_r <= 1'b0;
      gin_r <= '0;
      pout_r <= '0;
      poe_n_r <= '1;
      goe_n_r <= '1;
      pwm_r <= '0;
      run_r <= 1'b0;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      wdog_r <= wdog_nxt;
      jtag_r <= jtag_nxt;
      fac_r <= fac_nxt;
      alert_r <= alert_nxt;
      erase_r <= erase_nxt;
      wdrst_r <= wdrst_nxt;
      sum_r <= sum_nxt;
      st_r <= st_nxt;
      accept_r <= accept_nxt;
      pok_r <= pok_nxt;
      wword_r <= wword_nxt;
      rdata_r <= rdata_nxt;
      eerr_r <= eerr_nxt;
      gin_r <= gin_nxt;
      pout_r <= pout_nxt;
      poe_n_r <= poe_n_nxt;
      goe_n_r <= goe_n_nxt;
      pwm_r <= pwm_nxt;
      run_r <= run_nxt;
    end
  end

  assign jtag_en_o = jtag_r;
  assign gpio_in_o = gin_r;
  assign shared_pin_o = pout_r;
  assign shared_pin_oe_n_o = poe_n_r;
  assign gpio_oe_n_o = goe_n_r;
  assign fast_pulse_width_pin_o = pwm_r;
  assign bus_alert_output_o = alert_r;
  assign fw_run_o = run_r;
  assign factory_cfg_o = fac_r;
  assign log_erase_o = erase_r;
  assign log_sum_o = sum_r;
  assign soft_reset_o = wdrst_r;
  assign param_ok_o = pok_r;
  assign cmd_accept_o = accept_r;
  assign ecc_wword_o = wword_r;
  assign ecc_rdata_o = rdata_r;
  assign ecc_err_o = eerr_r;
  assign status_o = st_r;

endmodule

/* File: verif/bij_top_assertions.sv */
// assertion checker for the boot integrity block
`include "bij_defs.svh"
module bij_top_checker
  import bij_pkg::*;
#(
  parameter int unsigned ERASE_CYC = `BIJ_ERASE_CYC
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire bij_cmd_type cmd_i,
  input wire logic jtag_en_o,
  input wire logic [`BIJ_GPIO_JTAG_W-1:0] gpio_in_o,
  input wire logic [`BIJ_GPIO_JTAG_W-1:0] shared_pin_oe_n_o,
  input wire logic bus_alert_output_o,
  input wire logic factory_cfg_o,
  input wire logic log_erase_o,
  input wire logic fw_run_o,
  input wire logic param_ok_o,
  input wire logic cmd_accept_o,
  input wire bij_status_type status_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [31:0] erase_cnt_r;
  logic [31:0] erase_cnt_nxt;
  logic take;
  logic in_rng;
  assign take = cmd_i.valid && fw_run_o && (!cmd_i.pec_present || cmd_i.pec_ok);
  assign in_rng = cmd_i.value >= cmd_i.min && cmd_i.value <= cmd_i.max;
  ////////////////////
  // erase length counter, cleared whenever the erase flag drops
  always_comb begin
    erase_cnt_nxt = log_erase_o ? erase_cnt_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      erase_cnt_r <= 32'h0;
    end else begin
      erase_cnt_r <= erase_cnt_nxt;
    end
  end
  ////////////////////
  property p_jtag_hold;
    fw_run_o && $past(fw_run_o) |-> $stable(jtag_en_o);
  endproperty
  a_jtag_hold: assert property (p_jtag_hold) else $error("jtag changed while running");
  property p_jtag_pins;
    jtag_en_o && $past(jtag_en_o) |-> shared_pin_oe_n_o == 4'hF && gpio_in_o == 4'h0;
  endproperty
  a_jtag_pins: assert property (p_jtag_pins) else $error("shared pins not released");
  property p_accept;
    take && in_rng && cmd_i.code != `BIJ_ROM_MODE_CMD |-> ##[1:2] cmd_accept_o;
  endproperty
  a_accept: assert property (p_accept) else $error("good command not accepted");
  property p_range;
    take && !in_rng && cmd_i.code != `BIJ_ROM_MODE_CMD |-> ##[1:2] !param_ok_o
      && status_o.param_reject;
  endproperty
  a_range: assert property (p_range) else $error("out of range value kept");
  property p_pec_bad;
    cmd_i.valid && cmd_i.pec_present && !cmd_i.pec_ok |=> !cmd_accept_o [*2];
  endproperty
  a_pec_bad: assert property (p_pec_bad) else $error("bad check code accepted");
  property p_rom;
    take && cmd_i.code == `BIJ_ROM_MODE_CMD |-> ##[1:2] !fw_run_o;
  endproperty
  a_rom: assert property (p_rom) else $error("rom command left firmware running");
  property p_alert;
    bus_alert_output_o |-> factory_cfg_o && status_o.cfg_fallback;
  endproperty
  a_alert: assert property (p_alert) else $error("alert without fallback");
  property p_halt;
    status_o.fw_halted |-> !fw_run_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halted firmware running");
  property p_erase;
    $fell(log_erase_o) |-> erase_cnt_r == ERASE_CYC;
  endproperty
  a_erase: assert property (p_erase) else $error("erase length wrong");
  c_run: cover property ($rose(fw_run_o));
  c_erase: cover property ($fell(log_erase_o));
  c_acc: cover property (cmd_accept_o);
  c_jtag: cover property ($rose(jtag_en_o));
endmodule
bind bij_top bij_top_checker #(.ERASE_CYC(ERASE_CYC)) i_chk (
  .core_clk_i(core_clk_i),
  .resetn_i(resetn_i),
  .cmd_i(cmd_i),
  .jtag_en_o(jtag_en_o),
  .gpio_in_o(gpio_in_o),
  .shared_pin_oe_n_o(shared_pin_oe_n_o),
  .bus_alert_output_o(bus_alert_output_o),
  .factory_cfg_o(factory_cfg_o),
  .log_erase_o(log_erase_o),
  .fw_run_o(fw_run_o),
  .param_ok_o(param_ok_o),
  .cmd_accept_o(cmd_accept_o),
  .status_o(status_o)
);

/* File: verif/bij_bus_host.sv */
// management bus host model issuing command transfers
module bij_bus_host
  import bij_pkg::*;
(
  input wire logic core_clk_i,
  output bij_cmd_type cmd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cmd_o = '0;
  // one-cycle valid; released code and value show inverted data, never a stale copy
  task automatic send(input logic [7:0] c, input logic [15:0] v, input logic pec,
      input logic pok);
    @(posedge core_clk_i);
    cmd_o <= '{c, v, 16'h0010, 16'h0100, 1'b1, pec, pok};
    @(posedge core_clk_i);
    cmd_o <= '{~c, ~v, 16'h0010, 16'h0100, 1'b0, 1'b0, 1'b0};
  endtask
endmodule

/* File: verif/bij_top_tb_top.sv */
// self-checking testbench for the boot integrity block
`include "bij_defs.svh"
module bij_top_tb_top
  import bij_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  bij_boot_chk_type bchk = 4'hE;
  logic [6:0] addr = 7'h10;
  logic fault = 1'b0;
  logic kick = 1'b0;
  logic tool = 1'b0;
  logic log_wr = 1'b0;
  logic ecc_wr = 1'b0;
  logic ecc_rd = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [37:0] rword = 38'h0;
  logic [3:0] pin_in = 4'h5;
  logic clk_en = 1'b1;
  logic [3:0] gpio_out = 4'hA;
  logic [31:0] logsum = 32'hC0DE0001;
  bij_cmd_type cmd;
  logic jtag, alert, run, fcfg, erase, srst, pok, acc, eerr;
  logic [3:0] gpio_in, pin_out, pin_oe_n;
  logic [7:0] gpio_oe_n, pwm_o;
  logic [31:0] sum, rdata;
  logic [37:0] wword;
  bij_status_type st;
  int bad_count = 0;
  int n_checks = 0;
  always #25 clk = ~clk;
  bij_bus_host i_host (.core_clk_i(clk), .cmd_o(cmd));
  bij_top #(.ERASE_CYC(20), .WDOG_CYC(30)) i_dut (
    .core_clk_i(clk), .resetn_i(resetn), .clk_en_i(clk_en), .boot_chk_i(bchk),
    .bus_addr_i(addr), .addr_fault_i(fault), .wdog_kick_i(kick), .tool_connect_i(tool),
    .cmd_i(cmd), .shared_pin_i(pin_in), .gpio_out_i(gpio_out), .gpio_drive_i(8'h0F),
    .fast_pulse_width_pin_i(8'h5A), .log_wr_i(log_wr), .log_sum_i(logsum),
    .ecc_wr_i(ecc_wr), .ecc_wdata_i(wdata), .ecc_rd_i(ecc_rd), .ecc_rword_i(rword),
    .jtag_en_o(jtag), .gpio_in_o(gpio_in), .shared_pin_o(pin_out),
    .shared_pin_oe_n_o(pin_oe_n), .gpio_oe_n_o(gpio_oe_n), .fast_pulse_width_pin_o(pwm_o),
    .bus_alert_output_o(alert), .fw_run_o(run), .factory_cfg_o(fcfg),
    .log_erase_o(erase), .log_sum_o(sum), .soft_reset_o(srst), .param_ok_o(pok),
    .cmd_accept_o(acc), .ecc_wword_o(wword), .ecc_rdata_o(rdata), .ecc_err_o(eerr),
    .status_o(st));
  ////////////////////
  task automatic give_verdict();
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic await(ref logic s, input int n);
    for (int i = 0; i < n && s !== 1'b1; i++) @(negedge clk);
    if (s !== 1'b1) begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic boot(input bij_boot_chk_type c, input logic [6:0] a, input logic f);
    @(posedge clk);
    resetn <= 1'b0;
    bchk <= c;
    addr <= a;
    fault <= f;
    repeat (8) @(posedge clk);
    chk(gpio_oe_n, 8'hFF);
    chk(pwm_o, 8'h00);
    chk(jtag, 1'b0);
    resetn <= 1'b1;
  endtask
  // hamming layout: data fills positions that are not powers of two
  function automatic logic [5:0] ecc_bits(input logic [31:0] d);
    int p = 3;
    ecc_bits = 6'h0;
    for (int i = 0; i < 32; i++) begin
      while ((p & (p - 1)) == 0) p++;
      for (int k = 0; k < 6; k++) if (p[k]) ecc_bits[k] ^= d[i];
      p++;
    end
  endfunction
  task automatic acc_seen(input logic exp);
    logic hit = 1'b0;
    repeat (2) begin
      @(negedge clk);
      if (acc === 1'b1) hit = 1'b1;
    end
    chk(hit, exp);
  endtask
  ////////////////////
  task automatic t_normal();
    boot(4'hE, 7'h10, 1'b0);
    await(run, 10);
    repeat (4) @(negedge clk);
    chk(gpio_in, 4'h5);
    chk(pin_out, 4'hA);
    chk(gpio_oe_n, 8'hF0);
    chk(pwm_o, 8'h5A);
    chk(alert, 1'b0);
    // clock enable low: nothing may move while a write and a pin change wait
    @(posedge clk) gpio_out <= 4'h3;
    clk_en <= 1'b0;
    log_wr <= 1'b1;
    repeat (3) @(negedge clk);
    chk({pin_out, sum}, {4'hA, 32'h0});
    @(posedge clk) clk_en <= 1'b1;
    @(posedge clk) log_wr <= 1'b0;
    repeat (2) @(negedge clk);
    chk(sum, 32'hC0DE0001);
    chk(pin_out, 4'h3);
  endtask
  task automatic t_ecc();
    logic [31:0] flip[4] = '{32'h0, 32'h1, 32'h100, 32'h80000000};
    @(posedge clk) wdata <= 32'h1234ABCD;
    ecc_wr <= 1'b1;
    @(posedge clk) ecc_wr <= 1'b0;
    repeat (2) @(negedge clk);
    chk(wword, {ecc_bits(32'h1234ABCD), 32'h1234ABCD});
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) rword <= {ecc_bits(32'h1234ABCD), 32'h1234ABCD ^ flip[k]};
      ecc_rd <= 1'b1;
      @(posedge clk) ecc_rd <= 1'b0;
      repeat (2) @(negedge clk);
      chk(rdata, 32'h1234ABCD);
      chk(eerr, flip[k] != 32'h0);
    end
  endtask
  task automatic t_jtag();
    bij_boot_chk_type c[3] = '{4'hF, 4'hE, 4'hE};
    logic [6:0] a[3] = '{7'h10, 7'h7E, 7'h10};
    logic f[3] = '{1'b0, 1'b0, 1'b1};
    for (int k = 0; k < 3; k++) begin
      boot(c[k], a[k], f[k]);
      repeat (6) @(negedge clk);
      chk(jtag, 1'b1);
      chk(pin_oe_n, 4'hF);
      chk(gpio_in, 4'h0);
      @(posedge clk) addr <= 7'h13;
      fault <= 1'b0;
      repeat (5) @(negedge clk);
      chk(jtag, 1'b1);
    end
  endtask
  task automatic t_faults();
    int n = 0;
    boot(4'hA, 7'h10, 1'b0);
    await(run, 10);
    chk({alert, fcfg, st.cfg_fallback}, 3'h7);
    boot(4'hC, 7'h10, 1'b0);
    await(erase, 10);
    while (erase === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(n, 20);
    chk(st.log_erased, 1'b1);
    await(run, 5);
    boot(4'h6, 7'h10, 1'b0);
    repeat (30) @(negedge clk);
    chk({run, st.fw_halted}, 2'h1);
    i_host.send(8'h21, 16'h0040, 1'b0, 1'b0);
    acc_seen(1'b0);
    i_host.send(`BIJ_ROM_MODE_CMD, 16'h0040, 1'b0, 1'b0);
    repeat (2) @(negedge clk);
    chk({run, st.rom_mode}, 2'h1);
  endtask
  task automatic t_cmd();
    boot(4'hE, 7'h10, 1'b0);
    await(run, 10);
    i_host.send(8'h21, 16'h0040, 1'b0, 1'b0);
    acc_seen(1'b1);
    chk(pok, 1'b1);
    i_host.send(8'h21, 16'h0400, 1'b1, 1'b1);
    repeat (2) @(negedge clk);
    chk({pok, st.param_reject}, 2'h1);
    i_host.send(8'h21, 16'h0040, 1'b1, 1'b0);
    acc_seen(1'b0);
    i_host.send(8'h21, 16'h0040, 1'b1, 1'b1);
    acc_seen(1'b1);
    i_host.send(8'hD9, 16'h0040, 1'b0, 1'b0);
    repeat (2) @(negedge clk);
    chk({run, st.rom_mode}, 2'h1);
    @(posedge clk) tool <= 1'b1;
    await(srst, 5);
    @(posedge clk) tool <= 1'b0;
  endtask
  task automatic t_wdog();
    boot(4'hE, 7'h10, 1'b0);
    await(run, 10);
    repeat (4) begin
      repeat (10) begin
        @(negedge clk);
        chk(srst, 1'b0);
      end
      @(posedge clk) kick <= 1'b1;
      @(posedge clk) kick <= 1'b0;
    end
    await(srst, 40);
  endtask
  initial begin
    t_normal();
    t_ecc();
    t_jtag();
    t_faults();
    t_cmd();
    t_wdog();
    give_verdict();
  end
endmodule
